// ### rtl/fpio_top.v
// five-port configurable parallel i/o block with a classic wishbone register slave
//
// Chosen here: the Wishbone register port.
`timescale 1ns/100ps
// Operation
// - ports zero to three pins each pick input, quasi, push-pull or open-drain
// - tristate option set: ports zero to three reset into input-only, high impedance
// - option clear: ports one to three reset quasi, port zero open-drain
// - port four pins not handed to alternates behave quasi-bidirectional whatever is configured
// - port zero pull-ups on in quasi and push-pull modes
// - port four pins four to seven become general i/o unless handed to alternates
// - pin y mode comes from bit y of both mode select registers of its port
// - mode registers writable any time, back to defaults on every reset
`include "fpio_consts.vh"

module fpio_top
(
   // clock and reset
   input wire clk,
   input wire srst,
   // wishbone slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [9:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   // non-volatile default option: high selects ports zero to three tristated
   input wire tristate_default,
   // port four upper pins claimed by strobe and crystal functions
   input wire [3:0] alt_claim,
   // pins, port zero in bits 7:0 up to port four in bits 39:32
   input wire [39:0] pin_in,
   output reg [39:0] pin_out,
   output reg [39:0] pin_oe,
   output reg [39:0] pin_pullup
);

   // register state
   reg [39:0] latch;
   reg [39:0] sel_a;
   reg [39:0] sel_b;
   reg [39:0] latch_prev;
   // pin input synchronisers and filtered levels
   reg [39:0] in_s1;
   reg [39:0] in_s2;
   reg [39:0] in_s3;
   reg [39:0] in_level;
   // option bit synchroniser and filtered value
   reg opt_s1;
   reg opt_s2;
   reg opt_s3;
   reg opt_level;
   // decoder outputs
   reg dec_hit;
   reg [1:0] dec_kind;
   reg [2:0] dec_port;
   // bus helpers
   wire bus_req;
   wire bus_write;
   wire [7:0] reg_index;
   wire [5:0] byte_base;
   // per-pin next values
   wire [39:0] next_out;
   wire [39:0] next_oe;
   wire [39:0] next_pullup;
   // read mux result
   reg [7:0] next_rdata;
   // reset defaults chosen by the option bit
   wire [7:0] def_a_p0;
   wire [7:0] def_b_p0;
   wire [7:0] def_a_rest;
   wire [7:0] def_b_rest;

   // a request is served once; ack drops in the cycle after it was given
   assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign bus_write = bus_req & wb_we_i & wb_sel_i[0];
   assign reg_index = wb_adr_i[9:2];
   assign byte_base = {dec_port, 3'b000};

   // reset defaults follow the option bit
   assign def_a_p0 = opt_level ? `FPIO_SEL_A_INPUT : `FPIO_SEL_A_OPEN;
   assign def_b_p0 = opt_level ? `FPIO_SEL_B_INPUT : `FPIO_SEL_B_OPEN;
   assign def_a_rest = opt_level ? `FPIO_SEL_A_INPUT : `FPIO_SEL_A_QUASI;
   assign def_b_rest = opt_level ? `FPIO_SEL_B_INPUT : `FPIO_SEL_B_QUASI;

   // option bit synchroniser; its chain is never reset so it is valid during srst
   always @(posedge clk)
   begin
      opt_s1 <= tristate_default;
      opt_s2 <= opt_s1;
      opt_s3 <= opt_s2;
      if (opt_s2 == opt_s3)
      begin
         opt_level <= opt_s3;
      end
   end

   // pin input synchronisers; a level counts once the last two stages agree
   always @(posedge clk)
   begin
      if (srst)
      begin
         in_s1 <= 40'h00_0000_0000;
         in_s2 <= 40'h00_0000_0000;
         in_s3 <= 40'h00_0000_0000;
         in_level <= 40'h00_0000_0000;
      end
      else
      begin
         in_s1 <= pin_in;
         in_s2 <= in_s1;
         in_s3 <= in_s2;
         in_level <= (in_s3 & ~(in_s2 ^ in_s3)) | (in_level & (in_s2 ^ in_s3));
      end
   end

   // address decode of the fifteen mapped registers
   always @*
   begin
      dec_hit = 1'b1;
      dec_kind = `FPIO_KIND_DATA;
      dec_port = 3'd0;
      case (reg_index)
         `FPIO_IDX_PORT0_DATA: dec_port = 3'h0;
         `FPIO_IDX_PORT1_DATA: dec_port = 3'h1;
         `FPIO_IDX_PORT2_DATA: dec_port = 3'h2;
         `FPIO_IDX_PORT3_DATA: dec_port = 3'h3;
         `FPIO_IDX_PORT4_DATA: dec_port = 3'h4;
         `FPIO_IDX_PORT0_SEL_A:
         begin
            dec_port = 3'd0;
            dec_kind = `FPIO_KIND_SEL_A;
         end
         `FPIO_IDX_PORT0_SEL_B:
         begin
            dec_port = 3'd0;
            dec_kind = `FPIO_KIND_SEL_B;
         end
         `FPIO_IDX_PORT1_SEL_A:
         begin
            dec_port = 3'd1;
            dec_kind = `FPIO_KIND_SEL_A;
         end
         `FPIO_IDX_PORT1_SEL_B:
         begin
            dec_port = 3'd1;
            dec_kind = `FPIO_KIND_SEL_B;
         end
         `FPIO_IDX_PORT2_SEL_A:
         begin
            dec_port = 3'd2;
            dec_kind = `FPIO_KIND_SEL_A;
         end
         `FPIO_IDX_PORT2_SEL_B:
         begin
            dec_port = 3'd2;
            dec_kind = `FPIO_KIND_SEL_B;
         end
         `FPIO_IDX_PORT3_SEL_A:
         begin
            dec_port = 3'd3;
            dec_kind = `FPIO_KIND_SEL_A;
         end
         `FPIO_IDX_PORT3_SEL_B:
         begin
            dec_port = 3'd3;
            dec_kind = `FPIO_KIND_SEL_B;
         end
         `FPIO_IDX_PORT4_SEL_A:
         begin
            dec_port = 3'd4;
            dec_kind = `FPIO_KIND_SEL_A;
         end
         `FPIO_IDX_PORT4_SEL_B:
         begin
            dec_port = 3'd4;
            dec_kind = `FPIO_KIND_SEL_B;
         end
         default:
         begin
            dec_hit = 1'b0;
         end
      endcase
   end

   // read mux: data registers show filtered pin levels, mode registers their contents
   always @*
   begin
      next_rdata = 8'h00;
      if (dec_hit)
      begin
         case (dec_kind)
            `FPIO_KIND_DATA:
            begin
               next_rdata = in_level[byte_base +: 8];
            end
            `FPIO_KIND_SEL_A:
            begin
               next_rdata = sel_a[byte_base +: 8];
            end
            `FPIO_KIND_SEL_B:
            begin
               next_rdata = sel_b[byte_base +: 8];
            end
            default:
            begin
               next_rdata = 8'h00;
            end
         endcase
      end
   end

   // wishbone answer: one wait state, unmapped reads give zero, writes there are dropped
   always @(posedge clk)
   begin
      if (srst)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end
      else
      begin
         wb_ack_o <= bus_req;
         if (bus_req & ~wb_we_i)
         begin
            wb_dat_o <= {24'h00_0000, next_rdata};
         end
      end
   end

   // output latches and mode registers; defaults reload on every reset
   always @(posedge clk)
   begin
      if (srst)
      begin
         latch <= {5{`FPIO_LATCH_RST}};
         sel_a <= {def_a_rest, def_a_rest, def_a_rest, def_a_rest, def_a_p0};
         sel_b <= {def_b_rest, def_b_rest, def_b_rest, def_b_rest, def_b_p0};
         latch_prev <= {5{`FPIO_LATCH_RST}};
      end
      else
      begin
         latch_prev <= latch;
         if (bus_write & dec_hit)
         begin
            case (dec_kind)
               `FPIO_KIND_DATA:
               begin
                  latch[byte_base +: 8] <= wb_dat_i[`FPIO_DATA_MSB:`FPIO_DATA_LSB];
               end
               `FPIO_KIND_SEL_A:
               begin
                  sel_a[byte_base +: 8] <= wb_dat_i[`FPIO_DATA_MSB:`FPIO_DATA_LSB];
               end
               `FPIO_KIND_SEL_B:
               begin
                  sel_b[byte_base +: 8] <= wb_dat_i[`FPIO_DATA_MSB:`FPIO_DATA_LSB];
               end
               default:
               begin
                  latch <= latch;
               end
            endcase
         end
      end
   end

   // per-pin drive logic
   genvar gi;
   generate
      for (gi = 0; gi < 40; gi = gi + 1)
      begin : g_pin
         reg [1:0] mode;
         reg drv_out;
         reg drv_oe;
         reg drv_pu;
         wire claimed;
         wire kick;

         // upper port four pins may be handed to the strobe and crystal functions
         if (gi >= 36)
         begin : g_alt
            assign claimed = alt_claim[gi - 36];
         end
         else
         begin : g_noalt
            assign claimed = 1'b0;
         end

         // brief strong high when a quasi pin latch goes from low to high
         assign kick = latch[gi] & ~latch_prev[gi];

         // mode pair selection and pin drive per mode
         always @*
         begin
            mode = {sel_b[gi], sel_a[gi]};
            if (gi >= 32)
            begin
               mode = `FPIO_MODE_QUASI;
            end
            drv_out = 1'b0;
            drv_oe = 1'b0;
            drv_pu = 1'b0;
            case (mode)
               `FPIO_MODE_QUASI:
               begin
                  drv_out = latch[gi] & kick;
                  drv_oe = ~latch[gi] | kick;
                  drv_pu = 1'b1;
               end
               `FPIO_MODE_PUSH:
               begin
                  drv_out = latch[gi];
                  drv_oe = 1'b1;
                  drv_pu = 1'b1;
               end
               // input-only keeps the cleared drive set above
               `FPIO_MODE_INPUT: drv_oe = 1'b0;
               `FPIO_MODE_OPEN:
               begin
                  drv_out = 1'b0;
                  drv_oe = ~latch[gi];
                  drv_pu = 1'b0;
               end
               default:
               begin
                  drv_out = 1'b0;
                  drv_oe = 1'b0;
                  drv_pu = 1'b0;
               end
            endcase
            // a claimed pin is released by the port logic entirely
            if (claimed)
            begin
               drv_out = 1'b0;
               drv_oe = 1'b0;
               drv_pu = 1'b0;
            end
         end

         assign next_out[gi] = drv_out;
         assign next_oe[gi] = drv_oe;
         assign next_pullup[gi] = drv_pu;
      end
   endgenerate

   // pin drivers registered so every pin output comes from a flip-flop
   always @(posedge clk)
   begin
      if (srst)
      begin
         pin_out <= 40'h00_0000_0000;
         pin_oe <= 40'h00_0000_0000;
         pin_pullup <= 40'h00_0000_0000;
      end
      else
      begin
         pin_out <= next_out;
         pin_oe <= next_oe;
         pin_pullup <= next_pullup;
      end
   end

endmodule // fpio_top

// ### pkg/fpio_consts.vh
// register indices, reset values and mode codes of the five-port i/o block
`ifndef FPIO_CONSTS_VH
`define FPIO_CONSTS_VH

// register indices; the byte address is four times the index
`define FPIO_IDX_PORT0_DATA 8'h80
`define FPIO_IDX_PORT1_DATA 8'h90
`define FPIO_IDX_PORT2_DATA 8'hA0
`define FPIO_IDX_PORT3_DATA 8'hB0
`define FPIO_IDX_PORT4_DATA 8'hC0
`define FPIO_IDX_PORT4_SEL_A 8'hBE
`define FPIO_IDX_PORT4_SEL_B 8'hBF
`define FPIO_IDX_PORT3_SEL_A 8'hC6
`define FPIO_IDX_PORT3_SEL_B 8'hC7
`define FPIO_IDX_PORT2_SEL_A 8'hCE
`define FPIO_IDX_PORT2_SEL_B 8'hCF
`define FPIO_IDX_PORT1_SEL_A 8'hD6
`define FPIO_IDX_PORT1_SEL_B 8'hD7
`define FPIO_IDX_PORT0_SEL_A 8'hE6
`define FPIO_IDX_PORT0_SEL_B 8'hE7

// field layout of a register word: data sits in the low byte
`define FPIO_DATA_LSB 0
`define FPIO_DATA_MSB 7

// pin mode codes, {sel_b bit, sel_a bit}
`define FPIO_MODE_QUASI 2'h0
`define FPIO_MODE_PUSH 2'h1
`define FPIO_MODE_INPUT 2'h2
`define FPIO_MODE_OPEN 2'h3

// reset values
`define FPIO_LATCH_RST 8'hFF
`define FPIO_SEL_A_QUASI 8'h00
`define FPIO_SEL_B_QUASI 8'h00
`define FPIO_SEL_A_INPUT 8'h00
`define FPIO_SEL_B_INPUT 8'hFF
`define FPIO_SEL_A_OPEN 8'hFF
`define FPIO_SEL_B_OPEN 8'hFF

// register kinds seen by the decoder
`define FPIO_KIND_DATA 2'h0
`define FPIO_KIND_SEL_A 2'h1
`define FPIO_KIND_SEL_B 2'h2

// quasi-bidirectional strong high kick after a low-to-high latch change, cycles
`define FPIO_KICK_CYCLES 1

`endif

// ### testbench/fpio_top_monitor.sv
// checker of bus handshake and pin drive of the five-port i/o block
`timescale 1ns/100ps
module fpio_top_monitor
(
   // clock and reset
   input wire clk,
   input wire srst,
   // wishbone
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_ack_o,
   input wire [31:0] wb_dat_o,
   // pins
   input wire [3:0] alt_claim,
   input wire [39:0] pin_out,
   input wire [39:0] pin_oe,
   input wire [39:0] pin_pullup
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   // port four strong-high drive
   wire [7:0] p4_hi = pin_oe[39:32] & pin_out[39:32];
   a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing");
   a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   a_dat_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
      else $error("read data upper bits");
   a_dat_hold_idle: assert property (!wb_ack_o |-> $stable(wb_dat_o))
      else $error("read data moved");
   a_out_gated_oe: assert property ((pin_out & ~pin_oe) == 40'h0)
      else $error("out without enable");
   a_p4_quasi_only: assert property (!$past(srst) |->
      (pin_oe[39:32] | pin_pullup[39:32] | {$past(alt_claim), 4'h0}) == 8'hFF)
      else $error("port four not quasi");
   a_claim_release: assert property
      (((pin_oe[39:36] | pin_pullup[39:36]) & $past(alt_claim)) == 4'h0)
      else $error("claimed pin driven");
   a_p4_kick_short: assert property ((p4_hi & $past(p4_hi)) == 8'h0)
      else $error("port four high too long");
endmodule // fpio_top_monitor

bind fpio_top fpio_top_monitor u_fpio_top_monitor (.clk(clk), .srst(srst), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .alt_claim(alt_claim),
   .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup));

// ### testbench/fpio_pin_model.sv
// external circuitry on the forty port pins
`timescale 1ns/100ps
module fpio_pin_model
(
   // clock
   input wire clk,
   // block drive
   input wire [39:0] pin_out,
   input wire [39:0] pin_oe,
   input wire [39:0] pin_pullup,
   // external drivers
   input wire [39:0] ext_en,
   input wire [39:0] ext_val,
   // resolved levels
   output logic [39:0] pin_in
);
   logic flt = 1'b0;
   // an undriven wire shows a level that changes every cycle
   always @(posedge clk)
      flt <= ~flt;
   // strong drive wins, then external, then weak pull-up
   always_comb
      for (int i = 0; i < 40; i++)
         pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] : pin_pullup[i] | flt;
endmodule // fpio_pin_model

// ### testbench/testbench.sv
// self-checking bench of the five-port i/o block
`timescale 1ns/100ps
`include "fpio_consts.vh"
module testbench;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [9:0] adr = 10'h000;
   logic [3:0] sel = 4'hF;
   logic [3:0] wsel = 4'hF;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic ack;
   logic opt = 1'b1;
   logic [3:0] claim = 4'h0;
   logic [39:0] ext_en = 40'h0;
   logic [39:0] ext_val = 40'h0;
   logic [39:0] pin_in;
   logic [39:0] pin_out;
   logic [39:0] pin_oe;
   logic [39:0] pin_pu;
   int n_mismatch = 0;
   int total_checks = 0;

   fpio_top u_fpio_top (.clk(clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .tristate_default(opt), .alt_claim(claim), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe(pin_oe), .pin_pullup(pin_pu));
   fpio_pin_model u_fpio_pin_model (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
      .pin_pullup(pin_pu), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

   // 250 MHz clock
   initial
      forever #2 clk = ~clk;

   task test_done;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("FAIL %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // one classic cycle, held until ack is sampled high
   task bus(input logic w, input logic [7:0] idx, input logic [7:0] d, output logic [7:0] q);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= wsel;
      adr <= {idx, 2'h0};
      wdat <= {24'h0, d};
      @(posedge clk);
      while (ack !== 1'b1)
         @(posedge clk);
      q = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task wr(input logic [7:0] idx, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b1, idx, d, q);
   endtask

   task rd(input string nm, input logic [7:0] idx, input logic [7:0] exp);
      logic [7:0] q;
      bus(1'b0, idx, 8'h00, q);
      chk(nm, exp, q);
   endtask

   // pin drive of one port once the write has reached the pins
   task pins(input int p, input logic [7:0] oe, input logic [7:0] o, input logic [7:0] pu);
      repeat (3)
         @(posedge clk);
      chk("pin_oe", oe, pin_oe[8*p +: 8]);
      chk("pin_out", o, pin_out[8*p +: 8]);
      chk("pin_pullup", pu, pin_pu[8*p +: 8]);
   endtask

   task rst(input logic o, input logic [3:0] c);
      @(posedge clk);
      opt <= o;
      claim <= c;
      repeat (4)
         @(posedge clk);
      srst <= 1'b1;
      repeat (20)
         @(posedge clk);
      srst <= 1'b0;
   endtask

   // watchdog
   initial
   begin
      repeat (20000)
         @(posedge clk);
      n_mismatch++;
      $display("FAIL watchdog expected done seen hang");
      test_done;
   end

   initial
   begin
      // tristate option: ports zero to three input-only
      rst(1'b1, 4'h3);
      rd("p0 sel_a", `FPIO_IDX_PORT0_SEL_A, 8'h00);
      rd("p0 sel_b", `FPIO_IDX_PORT0_SEL_B, 8'hFF);
      for (int p = 0; p < 4; p++)
         pins(p, 8'h00, 8'h00, 8'h00);
      pins(4, 8'h00, 8'h00, 8'hCF);
      ext_en[23:16] <= 8'hFF;
      ext_val[23:16] <= 8'h5A;
      repeat (6)
         @(posedge clk);
      rd("p2 data", `FPIO_IDX_PORT2_DATA, 8'h5A);
      // port one pins 0..3 quasi, push-pull, input, open-drain
      wr(`FPIO_IDX_PORT1_SEL_A, 8'h0A);
      wr(`FPIO_IDX_PORT1_SEL_B, 8'h0C);
      wr(`FPIO_IDX_PORT1_DATA, 8'h00);
      pins(1, 8'hFB, 8'h00, 8'hF3);
      wr(`FPIO_IDX_PORT1_DATA, 8'hFF);
      pins(1, 8'h02, 8'h02, 8'hF3);
      rd("p1 sel_a", `FPIO_IDX_PORT1_SEL_A, 8'h0A);
      // a write without the low byte lane leaves the register alone
      wsel = 4'hE;
      wr(`FPIO_IDX_PORT1_SEL_A, 8'h55);
      wsel = 4'hF;
      rd("p1 sel_a lane", `FPIO_IDX_PORT1_SEL_A, 8'h0A);
      // port zero pull-ups in quasi then push-pull
      wr(`FPIO_IDX_PORT0_SEL_B, 8'h00);
      pins(0, 8'h00, 8'h00, 8'hFF);
      wr(`FPIO_IDX_PORT0_SEL_A, 8'hFF);
      pins(0, 8'hFF, 8'hFF, 8'hFF);
      // port four ignores its mode registers
      wr(`FPIO_IDX_PORT4_SEL_A, 8'hFF);
      rd("p4 sel_a", `FPIO_IDX_PORT4_SEL_A, 8'hFF);
      wr(`FPIO_IDX_PORT4_DATA, 8'h00);
      pins(4, 8'hCF, 8'h00, 8'hCF);
      wr(`FPIO_IDX_PORT4_DATA, 8'hFF);
      pins(4, 8'h00, 8'h00, 8'hCF);
      wr(8'h81, 8'hAA);
      rd("unmapped", 8'h81, 8'h00);
      // option clear: port zero open-drain, the others quasi
      rst(1'b0, 4'h0);
      rd("p0 sel_a", `FPIO_IDX_PORT0_SEL_A, 8'hFF);
      rd("p0 sel_b", `FPIO_IDX_PORT0_SEL_B, 8'hFF);
      rd("p1 sel_a", `FPIO_IDX_PORT1_SEL_A, 8'h00);
      rd("p3 sel_b", `FPIO_IDX_PORT3_SEL_B, 8'h00);
      rd("p4 sel_a", `FPIO_IDX_PORT4_SEL_A, 8'h00);
      pins(0, 8'h00, 8'h00, 8'h00);
      pins(1, 8'h00, 8'h00, 8'hFF);
      pins(4, 8'h00, 8'h00, 8'hFF);
      ext_en[15:8] <= 8'hFF;
      ext_val[15:8] <= 8'h3C;
      repeat (6)
         @(posedge clk);
      rd("p1 data", `FPIO_IDX_PORT1_DATA, 8'h3C);
      test_done;
   end
endmodule // testbench
